// file: boot_isp_pkg.sv
// package for the boot select and serial record loader
// assumes a single pclk domain at 10 MHz, apb register access
package boot_isp_pkg;
	// timing
	localparam int unsigned CLK_HZ         = 10000000;
	localparam int unsigned RX_MAX_CYC     = 65535;    // longest bit measured
	// start addresses
	localparam logic [15:0] APP_START      = 16'h0000;
	localparam logic [7:0]  START_LOW      = 8'h00;
	localparam logic [7:0]  VECTOR_DEFAULT = 8'hfc;    // rom loader page
	localparam logic [7:0]  STATUS_DEFAULT = 8'hff;    // loader on first boot
	localparam logic [7:0]  ERASED_BYTE    = 8'h00;    // value after erase
	// characters
	localparam logic [7:0]  CH_U           = 8'h55;
	localparam logic [7:0]  CH_COLON       = 8'h3a;
	localparam logic [7:0]  CH_CR          = 8'h0d;
	localparam logic [7:0]  CH_LF          = 8'h0a;
	localparam logic [7:0]  CH_DOT         = 8'h2e;
	localparam logic [7:0]  CH_X           = 8'h58;
	localparam logic [7:0]  CH_R           = 8'h52;
	// record types
	localparam logic [7:0]  REC_DATA       = 8'h00;
	localparam logic [7:0]  REC_EOF        = 8'h01;
	localparam logic [7:0]  REC_OSC        = 8'h02;
	localparam logic [7:0]  REC_MISC_WR    = 8'h03;
	localparam logic [7:0]  REC_DISPLAY    = 8'h04;
	localparam logic [7:0]  SUB_ERASE_BOOT = 8'h04;
	localparam logic [7:0]  SUB_PROG_BOOT  = 8'h06;
	localparam int unsigned MAX_DATA       = 16;
	// register offsets
	localparam logic [7:0]  OFF_CTRL       = 8'h00;
	localparam logic [7:0]  OFF_STATUS     = 8'h04;
	localparam logic [7:0]  OFF_START      = 8'h08;
	localparam logic [7:0]  OFF_BAUD       = 8'h0c;
	localparam logic [7:0]  OFF_RECORD     = 8'h10;
	localparam logic [7:0]  OFF_NVBYTES    = 8'h14;
	localparam logic [7:0]  OFF_PROG       = 8'h18;
	// field positions
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned STAT_BAUD_BIT  = 0;
	localparam int unsigned STAT_BUSY_BIT  = 1;
	localparam int unsigned STAT_FAIL_BIT  = 2;
	localparam int unsigned STAT_OSC_BIT   = 3;
	localparam int unsigned STAT_ERR_BIT   = 4;
	typedef enum {
		P_IDLE, P_HI, P_LO, P_END_CR, P_END_LF
	} parse_state_t;
endpackage : boot_isp_pkg

// file: baud_detect.sv
// measures one bit time on the serial input from the first start bit
// assumes rx is synchronous to pclk and idle high
`timescale 1ns/1ps
module baud_detect
	import boot_isp_pkg::*;
#(
	parameter int CNT_W = 16
)(
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	// serial input
	input  wire logic             rx,
	// result
	output logic                  locked,
	output logic [CNT_W-1:0]      bit_cycles
);
	typedef enum { B_WAIT, B_MEAS, B_DONE } meas_t;
	meas_t            st_reg, st_next;        // measuring state
	logic [CNT_W-1:0] cnt_reg, cnt_next;      // cycles in the low bit
	logic [CNT_W-1:0] res_reg, res_next;      // captured bit time

	// the start bit of 'U' is exactly one bit wide, so its low time is the bit
	always_comb begin
		st_next  = st_reg;
		cnt_next = cnt_reg;
		res_next = res_reg;
		case (st_reg)
			B_WAIT: begin
				if (!rx) begin
					st_next  = B_MEAS;
					cnt_next = CNT_W'(1);
				end
			end
			B_MEAS: begin
				if (rx) begin
					res_next = cnt_reg;
					st_next  = B_DONE;
				end else if (cnt_reg != {CNT_W{1'b1}}) begin
					cnt_next = cnt_reg + CNT_W'(1);
				end
			end
			default: ; // locked until reset
		endcase
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg  <= B_WAIT;
			cnt_reg <= '0;
			res_reg <= '0;
		end else if (ce) begin
			st_reg  <= st_next;
			cnt_reg <= cnt_next;
			res_reg <= res_next;
		end
	end

	assign locked     = (st_reg == B_DONE);
	assign bit_cycles = res_reg;

	// the captured time equals the low time just ended
	a_bit_capture: assert property (@(posedge pclk) disable iff (!presetn)
		ce && st_reg == B_MEAS && rx |=> locked && bit_cycles == $past(cnt_reg))
		else $error("bit time not captured");
endmodule : baud_detect

// file: hex_nibble.sv
// ascii hex digit decoder, combinational
// assumes upper or lower case digits
`timescale 1ns/1ps
module hex_nibble (
	// character in
	input  wire logic [7:0] ch,
	// decoded value
	output logic [3:0]      val,
	output logic            ok
);
	// digits, then letters a-f in either case
	always_comb begin
		val = 4'h0;
		ok  = 1'b1;
		if (ch >= 8'h30 && ch <= 8'h39)
			val = ch[3:0];
		else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66))
			val = ch[3:0] + 4'h9;
		else
			ok = 1'b0;
	end
endmodule : hex_nibble

// file: boot_isp_loader.sv
// boot start selection and serial record loader
// How it works
// - read status byte as reset rises
// - zero status starts at application address
// - nonzero status uses vector, low zero
// - vector defaults to rom loader page
// - erasing either byte clears both
// - strap pins force loader like nonzero status
// - baud from timing one received bit
// - echo every received character, except the closing lf of any record but a good nonempty data record: answered in its place, or dropped for type 04
// - accept only hex records after baud
// - at most sixteen data bytes
// - type 00 data, 01 end of file
// - buffer record, act only when complete
// - bad checksum answers X, no action
// - good record answers period, except type 04 display, which gets no answer
// - data record answers R on failure
// assumes a uart outside feeds rx_valid/rx_data and takes tx_valid/tx_data;
// flash programming happens outside, via prog_req/prog_done/prog_ok
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
module boot_isp_loader
	import boot_isp_pkg::*;
#(
	parameter int BAUD_W = 16
)(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// strap pins, sampled as reset rises
	input  wire logic        program_store_strobe_n,
	input  wire logic [1:0]  port2_hi,
	input  wire logic        external_access_select_n,
	input  wire logic        address_latch_strobe,
	// serial line and uart byte path
	input  wire logic        rx_line,
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	// flash byte programming
	output logic             prog_req,
	output logic [15:0]      prog_addr,
	output logic [7:0]       prog_data,
	input  wire logic        prog_done,
	input  wire logic        prog_ok,
	// boot result
	output logic [15:0]      start_addr,
	output logic             start_valid,
	// apb
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	// boot state
	logic [7:0]  stat_reg, stat_next;    // nonvolatile status byte
	logic [7:0]  vec_reg, vec_next;      // nonvolatile boot vector
	logic [15:0] start_reg, start_next;  // chosen start address
	logic        sv_reg, sv_next;        // start address captured
	// parser state
	parse_state_t ps_reg, ps_next;
	logic [7:0]  buf_reg [0:MAX_DATA+4]; // count, addr, type, data, sum
	logic [7:0]  buf_next [0:MAX_DATA+4];
	logic [4:0]  idx_reg, idx_next;      // decoded bytes so far
	logic [3:0]  hi_reg, hi_next;        // first nibble held
	logic [7:0]  sum_reg, sum_next;      // running checksum
	logic [7:0]  osc_reg, osc_next;      // oscillator megahertz
	logic        osc_set_reg, osc_set_next;
	logic        en_reg, en_next;        // loader enable
	logic        err_reg, err_next;      // framing errors seen
	// execution
	logic        busy_reg, busy_next;    // programming a data record
	logic [4:0]  pi_reg, pi_next;        // data byte being programmed
	logic        fail_reg, fail_next;    // any byte failed
	logic        preq_reg, preq_next;
	// reply
	logic        txv_reg, txv_next;
	logic [7:0]  txd_reg, txd_next;
	// apb read data
	logic [31:0] rd_reg, rd_next;
	// helpers
	logic [3:0]  nib;
	logic        nib_ok;
	logic        locked;
	logic [BAUD_W-1:0] bit_cyc;
	logic [7:0]  cnt_b, typ_b, rec_len;
	logic        strap;
	logic        apb_go;

	baud_detect #(.CNT_W(BAUD_W)) u_baud (
		.pclk(pclk), .presetn(presetn), .ce(ce), .rx(rx_line),
		.locked(locked), .bit_cycles(bit_cyc)
	);
	hex_nibble u_nib (.ch(rx_data), .val(nib), .ok(nib_ok));

	assign cnt_b   = buf_reg[0];
	assign typ_b   = buf_reg[3];
	assign rec_len = cnt_b + 8'h05;
	assign strap   = !program_store_strobe_n && (&port2_hi)
	                 && external_access_select_n && address_latch_strobe;
	assign apb_go  = psel && penable;

	// boot choice and nonvolatile bytes
	always_comb begin
		stat_next  = stat_reg;
		vec_next   = vec_reg;
		start_next = start_reg;
		sv_next    = 1'b1;
		if (!sv_reg) begin
			if (stat_reg == 8'h00 && !strap)
				start_next = APP_START;
			else
				start_next = {vec_reg, START_LOW};
		end
		// record-driven updates on a completed good record
		if (ps_reg == P_END_LF && rx_valid && rx_data == CH_LF
		    && sum_reg == 8'h00 && typ_b == REC_MISC_WR) begin
			if (buf_reg[4] == SUB_ERASE_BOOT) begin
				stat_next = ERASED_BYTE;
				vec_next  = ERASED_BYTE;
			end else if (buf_reg[4] == SUB_PROG_BOOT) begin
				if (buf_reg[5] == 8'h00)
					stat_next = buf_reg[6];
				else
					vec_next = buf_reg[6];
			end
		end
		// software write of both bytes
		if (apb_go && pwrite && paddr == OFF_NVBYTES) begin
			stat_next = pwdata[7:0];
			vec_next  = pwdata[15:8];
		end
	end

	// boot registers; nonvolatile bytes take factory defaults on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_reg  <= STATUS_DEFAULT;
			vec_reg   <= VECTOR_DEFAULT;
			start_reg <= APP_START;
			sv_reg    <= 1'b0;
		end else if (ce) begin
			stat_reg  <= stat_next;
			vec_reg   <= vec_next;
			start_reg <= start_next;
			sv_reg    <= sv_next;
		end
	end

	// record parser, programming and replies
	always_comb begin
		ps_next      = ps_reg;
		buf_next     = buf_reg;
		idx_next     = idx_reg;
		hi_next      = hi_reg;
		sum_next     = sum_reg;
		osc_next     = osc_reg;
		osc_set_next = osc_set_reg;
		err_next     = err_reg;
		busy_next    = busy_reg;
		pi_next      = pi_reg;
		fail_next    = fail_reg;
		preq_next    = preq_reg;
		txv_next     = txv_reg && !tx_ready;
		txd_next     = txd_reg;
		en_next      = en_reg;
		if (apb_go && pwrite && paddr == OFF_CTRL)
			en_next = pwdata[CTRL_EN_BIT];
		if (rx_valid && en_reg) begin
			txv_next = 1'b1;
			txd_next = rx_data;
		end
		if (rx_valid && en_reg && locked && !busy_reg) begin
			case (ps_reg)
				P_IDLE: begin
					if (rx_data == CH_COLON) begin
						ps_next  = P_HI;
						idx_next = 5'd0;
						sum_next = 8'h00;
					end
				end
				P_HI: begin
					if (!nib_ok) begin
						ps_next  = (rx_data == CH_COLON) ? P_HI : P_IDLE;
						idx_next = 5'd0;
						sum_next = 8'h00;
						err_next = 1'b1;
					end else begin
						hi_next = nib;
						ps_next = P_LO;
					end
				end
				P_LO: begin
					if (!nib_ok) begin
						ps_next  = P_IDLE;
						err_next = 1'b1;
					end else begin
						buf_next[idx_reg] = {hi_reg, nib};
						sum_next = sum_reg + {hi_reg, nib};
						idx_next = idx_reg + 5'd1;
						ps_next  = P_HI;
						if (idx_reg == 5'd0 && {hi_reg, nib} > 8'(MAX_DATA)) begin
							ps_next  = P_IDLE;
							err_next = 1'b1;
						end else if (idx_reg != 5'd0
						             && {3'b000, idx_reg} + 8'h01 == rec_len)
							ps_next = P_END_CR;
					end
				end
				P_END_CR: begin
					ps_next = (rx_data == CH_CR) ? P_END_LF : P_IDLE;
					err_next = err_reg || rx_data != CH_CR;
				end
				default: begin // P_END_LF: whole record now in hand
					ps_next = P_IDLE;
					if (rx_data != CH_LF) begin
						err_next = 1'b1;
					end else if (sum_reg != 8'h00) begin
						txv_next = 1'b1;
						txd_next = CH_X;
					end else if (typ_b == REC_DATA && cnt_b != 8'h00) begin
						busy_next = 1'b1;
						pi_next   = 5'd0;
						fail_next = 1'b0;
						preq_next = 1'b1;
					end else if (typ_b == REC_DISPLAY) begin
						txv_next = 1'b0;
					end else begin
						if (typ_b == REC_OSC) begin
							osc_next     = buf_reg[4];
							osc_set_next = 1'b1;
						end
						txv_next = 1'b1;
						txd_next = CH_DOT;
					end
				end
			endcase
		end
		// byte-by-byte programming of a data record
		if (busy_reg && prog_done) begin
			fail_next = fail_reg || !prog_ok;
			if ({3'b000, pi_reg} + 8'h01 == cnt_b) begin
				busy_next = 1'b0;
				preq_next = 1'b0;
				txv_next  = 1'b1;
				txd_next  = (fail_reg || !prog_ok) ? CH_R : CH_DOT;
			end else begin
				pi_next = pi_reg + 5'd1;
			end
		end
	end

	// parser registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ps_reg      <= P_IDLE;
			for (int i = 0; i <= MAX_DATA + 4; i++)
				buf_reg[i] <= 8'h00;
			idx_reg     <= 5'd0;
			hi_reg      <= 4'h0;
			sum_reg     <= 8'h00;
			osc_reg     <= 8'h00;
			osc_set_reg <= 1'b0;
			err_reg     <= 1'b0;
			busy_reg    <= 1'b0;
			pi_reg      <= 5'd0;
			fail_reg    <= 1'b0;
			preq_reg    <= 1'b0;
			txv_reg     <= 1'b0;
			txd_reg     <= 8'h00;
			en_reg      <= 1'b1;
		end else if (ce) begin
			ps_reg      <= ps_next;
			buf_reg     <= buf_next;
			idx_reg     <= idx_next;
			hi_reg      <= hi_next;
			sum_reg     <= sum_next;
			osc_reg     <= osc_next;
			osc_set_reg <= osc_set_next;
			err_reg     <= err_next;
			busy_reg    <= busy_next;
			pi_reg      <= pi_next;
			fail_reg    <= fail_next;
			preq_reg    <= preq_next;
			txv_reg     <= txv_next;
			txd_reg     <= txd_next;
			en_reg      <= en_next;
		end
	end

	// apb read mux, zero on unmapped
	always_comb begin
		rd_next = rd_reg;
		if (psel && !penable && !pwrite) begin
			if (paddr == OFF_CTRL)
				rd_next = {31'h0, en_reg};
			else if (paddr == OFF_STATUS)
				rd_next = {27'h0, err_reg, osc_set_reg, fail_reg, busy_reg,
				           locked};
			else if (paddr == OFF_START)
				rd_next = {16'h0, start_reg};
			else if (paddr == OFF_BAUD)
				rd_next = 32'(bit_cyc);
			else if (paddr == OFF_RECORD)
				rd_next = {16'h0, osc_reg, typ_b};
			else if (paddr == OFF_NVBYTES)
				rd_next = {16'h0, vec_reg, stat_reg};
			else if (paddr == OFF_PROG)
				rd_next = {27'h0, pi_reg};
			else
				rd_next = 32'h0;
		end
	end

	// apb read register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_reg <= 32'h0;
		else if (ce)
			rd_reg <= rd_next;
	end

	assign prdata      = rd_reg;
	assign pready      = 1'b1;    // one-cycle access phase
	assign pslverr     = 1'b0;
	assign tx_valid    = txv_reg;
	assign tx_data     = txd_reg;
	assign prog_req    = preq_reg;
	assign prog_addr   = {buf_reg[1], buf_reg[2]} + {11'h0, pi_reg};
	assign prog_data   = buf_reg[5'd4 + pi_reg];
	assign start_addr  = start_reg;
	assign start_valid = sv_reg;

	a_boot_zero: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !sv_reg && stat_reg == 8'h00 && !strap
		|=> start_addr == APP_START) else $error("app start wrong");
	a_boot_vec: assert property (@(posedge pclk) disable iff (!presetn)
		ce && !sv_reg && (stat_reg != 8'h00 || strap)
		|=> start_addr == {$past(vec_reg), 8'h00})
		else $error("vector start wrong");
	// a record's closing lf and a finished data record answer instead
	a_echo_char: assert property (@(posedge pclk) disable iff (!presetn)
		ce && rx_valid && en_reg && !(busy_reg && prog_done)
		&& !(locked && !busy_reg && ps_reg == P_END_LF)
		|=> tx_valid && tx_data == $past(rx_data))
		else $error("no echo");
	a_bad_sum: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ps_reg == P_END_LF && rx_valid && en_reg && locked
		&& !busy_reg && rx_data == CH_LF && sum_reg != 8'h00
		|=> tx_data == CH_X && !busy_reg) else $error("no X");
	a_erase_both: assert property (@(posedge pclk) disable iff (!presetn)
		ce && ps_reg == P_END_LF && rx_valid && rx_data == CH_LF
		&& sum_reg == 8'h00 && typ_b == REC_MISC_WR
		&& buf_reg[4] == SUB_ERASE_BOOT && !(apb_go && pwrite)
		|=> stat_reg == 8'h00 && vec_reg == 8'h00)
		else $error("erase split");
	a_prog_fail: assert property (@(posedge pclk) disable iff (!presetn)
		ce && busy_reg && prog_done && !prog_ok
		&& {3'b000, pi_reg} + 8'h01 == cnt_b |=> tx_data == CH_R)
		else $error("no R");
	a_count_cap: assert property (@(posedge pclk) disable iff (!presetn)
		ce && busy_reg |-> cnt_b <= 8'(MAX_DATA))
		else $error("too many bytes");
	a_resync: assert property (@(posedge pclk) disable iff (!presetn)
		ce && rx_valid && en_reg && locked && !busy_reg
		&& ps_reg == P_IDLE && rx_data != CH_COLON |=> ps_reg == P_IDLE)
		else $error("left idle on junk");
endmodule : boot_isp_loader

// file: host_model.sv
// host programming tool: serial frames, byte strobes, reply capture
// assumes the loader's pclk; one byte outstanding at a time
`timescale 1ns/1ps
module host_model #(
	parameter int BIT = 8 // pclk cycles per serial bit
)(
	// clock
	input  wire logic       pclk,
	// host to loader
	output logic            rx_line,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	// loader to host
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] rxq[$];            // characters taken from the loader
	int         seed = 32'h18f87dc1; // fixed, so stalls repeat

	// idle line high, nothing offered
	initial begin
		rx_line = 1'b1;
		rx_valid = 1'b0;
		rx_data = 8'h00;
	end

	// take replies; random stalls exercise the held tx level
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
		tx_ready <= ($random(seed) % 3) != 0;
	end

	// frame lsb first, strobe the byte, then wait for its answer
	task put(input logic [7:0] ch);
		logic [9:0] fr;
		int         n;
		int         t;
		fr = {1'b1, ch, 1'b0};
		n = rxq.size();
		for (int i = 0; i < 10; i++) begin
			repeat (BIT) @(posedge pclk);
			rx_line <= fr[i];
		end
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= ch;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~ch; // released: never the last value
		t = 0;
		// no next byte until this one is answered or 3000 cycles pass
		while (rxq.size() == n && t < 3000) begin
			@(posedge pclk);
			t++;
		end
	endtask : put
endmodule : host_model

// file: boot_isp_loader_tb_top.sv
// self-checking bench for the boot select and record loader
// assumes host_model as serial partner and a flash responder here
`timescale 1ns/1ps
module boot_isp_loader_tb_top import boot_isp_pkg::*; ;
	localparam int BIT = 8; // short serial bit keeps the run brief
	logic pclk, presetn, ce, program_store_strobe_n;
	logic [1:0] port2_hi;
	logic external_access_select_n, address_latch_strobe;
	logic rx_line, rx_valid, tx_valid, tx_ready, prog_req, prog_done;
	logic [7:0] rx_data, tx_data, prog_data, paddr;
	logic [15:0] prog_addr, start_addr;
	logic prog_ok, start_valid, psel, penable, pwrite, pready, pslverr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] padr[$]; // flash addresses seen
	logic [7:0]  pdat[$]; // flash bytes seen
	logic [7:0]  d[$];
	logic [15:0] a;
	logic        fail_pg; // flash answers failure when set
	int fail_count = 0, checks = 0, cyc = 0, pwait = 0, n;
	int seed = 32'h18f87dc1;

	boot_isp_loader dut(.pclk, .presetn, .ce, .program_store_strobe_n,
		.port2_hi, .external_access_select_n, .address_latch_strobe,
		.rx_line, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready,
		.prog_req, .prog_addr, .prog_data, .prog_done, .prog_ok,
		.start_addr, .start_valid, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	host_model #(.BIT(BIT)) host(.pclk, .rx_line, .rx_valid, .rx_data,
		.tx_valid, .tx_data, .tx_ready);

	// 100 ns clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// flash: first byte after four cycles, then one per five, result with the done pulse
	always @(posedge pclk) begin
		prog_done <= 1'b0;
		if (prog_req && !prog_done && pwait == 3) begin
			prog_done <= 1'b1;
			prog_ok <= ~fail_pg;
			padr.push_back(prog_addr);
			pdat.push_back(prog_data);
			pwait <= 0;
		end else if (prog_req && !prog_done)
			pwait <= pwait + 1;
	end

	// hang guard, well above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			complete_run;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, string m);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	function logic [7:0] hx(input logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + {4'h0, v} : 8'h37 + {4'h0, v};
	endfunction : hx

	// setup then access; waits for pready, reads at that edge
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// whole record with checksum (optionally spoiled), then the reply
	task rec(input logic [7:0] b[$], input logic bad, input logic [7:0] rp);
		logic [7:0] s;
		int         n0;
		int         ex;
		int         t;
		s = 8'h00;
		n0 = host.rxq.size();
		foreach (b[i]) s += b[i];
		b.push_back((8'h00 - s) ^ {7'h00, bad});
		host.put(CH_COLON);
		foreach (b[i]) begin
			host.put(hx(b[i][7:4]));
			host.put(hx(b[i][3:0]));
		end
		host.put(CH_CR);
		host.put(CH_LF);
		// a good data record echoes its lf, then answers once programmed
		ex = 2 * b.size() + 3 + ((b[3] == REC_DATA && !bad) ? 1 : 0);
		t = 0;
		while (host.rxq.size() - n0 < ex && t < 3000) begin
			@(posedge pclk);
			t++;
		end
		chk(host.rxq.size() - n0, ex, "echo count");
		chk({24'h0, host.rxq[$]}, {24'h0, rp}, "reply");
	endtask : rec

	// reset with straps set or clear; loader start expected either way
	task rst(input logic s);
		@(posedge pclk);
		presetn <= 1'b0;
		program_store_strobe_n <= ~s;
		port2_hi <= {2{s}};
		external_access_select_n <= s;
		address_latch_strobe <= s;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({31'h0, start_valid}, 32'h1, "start valid");
		chk({16'h0, start_addr}, {16'h0, VECTOR_DEFAULT, START_LOW},
		    "start");
	endtask : rst

	task complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	initial begin
		{presetn, psel, penable, pwrite, prog_done, prog_ok, fail_pg} = '0;
		{program_store_strobe_n, port2_hi} = '0;
		{external_access_select_n, address_latch_strobe} = '0;
		ce = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		rst(1'b0);
		apb(1'b0, OFF_NVBYTES, 32'h0);
		chk(r, 32'h0000fcff, "nv defaults");
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r, 32'h1, "ctrl reset");
		apb(1'b1, 8'h1c, 32'hffffffff);
		apb(1'b0, 8'h1c, 32'h0);
		chk(r, 32'h0, "unmapped");
		// a write while the enable is low must not land
		ce <= 1'b0;
		apb(1'b1, OFF_CTRL, 32'h0);
		ce <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk(r, 32'h1, "frozen by ce");
		$display("test boot done");
		host.put(CH_U);
		chk({24'h0, host.rxq[$]}, {24'h0, CH_U}, "echo U");
		apb(1'b0, OFF_STATUS, 32'h0);
		chk({31'h0, r[STAT_BAUD_BIT]}, 32'h1, "locked");
		apb(1'b0, OFF_BAUD, 32'h0);
		chk({31'h0, r >= BIT - 1 && r <= BIT + 1}, 32'h1, "bit");
		$display("test baud done");
		rec('{8'h01, 8'h00, 8'h00, REC_OSC, 8'h0a}, 1'b0, CH_DOT);
		apb(1'b0, OFF_RECORD, 32'h0);
		chk({24'h0, r[15:8]}, 32'h0a, "osc mhz");
		rec('{8'h00, 8'h00, 8'h00, REC_EOF}, 1'b0, CH_DOT);
		rec('{8'h00, 8'h00, 8'h00, REC_EOF}, 1'b1, CH_X);
		host.put(8'h5a);
		chk({24'h0, host.rxq[$]}, 32'h5a, "junk echo");
		rec('{8'h00, 8'h12, 8'h34, REC_EOF}, 1'b0, CH_DOT);
		$display("test records done");
		for (int k = 0; k < 4; k++) begin
			n = (k == 0) ? 16 : (k == 1) ? 1 : 1 + ({$random(seed)} % 16);
			a = $random(seed) & 16'h7ff0;
			d = '{8'(n), a[15:8], a[7:0], REC_DATA};
			for (int i = 0; i < n; i++) d.push_back($random(seed));
			padr.delete();
			pdat.delete();
			fail_pg <= (k == 3);
			rec(d, 1'b0, (k == 3) ? CH_R : CH_DOT);
			if (k < 3) begin
				chk(padr.size(), n, "byte count");
				foreach (pdat[i]) begin
					chk({16'h0, padr[i]}, {16'h0, 16'(a + i)}, "addr");
					chk({24'h0, pdat[i]}, {24'h0, d[4+i]}, "data");
				end
			end
		end
		$display("test data done");
		d = '{8'h02, 8'h00, 8'h00, REC_MISC_WR, SUB_ERASE_BOOT, 8'h00};
		rec(d, 1'b0, CH_DOT);
		apb(1'b0, OFF_NVBYTES, 32'h0);
		chk(r, {16'h0, ERASED_BYTE, ERASED_BYTE}, "erase both");
		d = '{8'h03, 8'h00, 8'h00, REC_MISC_WR, SUB_PROG_BOOT, 8'h01, 8'hfc};
		rec(d, 1'b0, CH_DOT);
		d = '{8'h03, 8'h00, 8'h00, REC_MISC_WR, SUB_PROG_BOOT, 8'h00, 8'h00};
		rec(d, 1'b0, CH_DOT);
		apb(1'b0, OFF_NVBYTES, 32'h0);
		chk(r, 32'h0000fc00, "nv rewritten");
		apb(1'b1, OFF_NVBYTES, 32'h00005a00);
		apb(1'b0, OFF_NVBYTES, 32'h0);
		chk(r, 32'h00005a00, "nv apb write");
		$display("test nv done");
		rst(1'b1);
		$display("test strap done");
		complete_run;
	end
endmodule : boot_isp_loader_tb_top
